// ==== rtl/ppr_ports.sv ====
`timescale 1ns/1ps
// Functional notes
// - Oscillator output clock pin leaves GPIO
// - Oscillator input clock pin leaves GPIO
// - Fuse programmed makes bit 0 plain I/O
// - Fuse unprogrammed routes bit 0 to reset
// - Reset pin bits 0 read as zero
// - Compare B overrides bit-1 output value
// - Channel 0 disables bit-2 input; others off
// - Output-value registers eight bits, reset zero
// - Direction registers eight bits, reset input
// - Pin-input registers follow pins via the synchroniser, reset zero
// - Port E bits 7..3 read zero
module ppr_ports
  import ppr_pkg::*;
(
  input wire logic clk, // 50 MHz clock
  input wire logic rstn, // Sync reset, active low
  input wire logic [ppr_pkg::PPR_AW-1:0] addr, // Register offset
  input wire logic [ppr_pkg::PPR_DW-1:0] wdata, // Write data
  input wire logic we, // Write strobe
  input wire logic re, // Read strobe
  output logic [ppr_pkg::PPR_DW-1:0] rdata, // Read data, cycle after re
  input wire logic [7:0] pb_in, // Port B pin levels
  output logic [7:0] pb_out, // Port B drive value
  output logic [7:0] pb_oe, // Port B drive enable
  output logic [7:0] pb_pullup, // Port B pull-up enable
  input wire logic [7:0] pc_in, // Port C pin levels
  output logic [7:0] pc_out, // Port C drive value
  output logic [7:0] pc_oe, // Port C drive enable
  output logic [7:0] pc_pullup, // Port C pull-up enable
  input wire logic [7:0] pd_in, // Port D pin levels
  output logic [7:0] pd_out, // Port D drive value
  output logic [7:0] pd_oe, // Port D drive enable
  output logic [7:0] pd_pullup, // Port D pull-up enable
  input wire logic [ppr_pkg::PPR_PE_W-1:0] pe_in, // Port E pin levels
  output logic [ppr_pkg::PPR_PE_W-1:0] pe_out, // Port E drive value
  output logic [ppr_pkg::PPR_PE_W-1:0] pe_oe, // Port E drive enable
  output logic [ppr_pkg::PPR_PE_W-1:0] pe_pullup, // Port E pull-up enable
  input wire logic reset_pin_disable_fuse, // High: fuse programmed
  input wire logic osc_in_clk_sel, // Clock uses oscillator input pin
  input wire logic osc_out_clk_sel, // Clock uses oscillator output pin
  input wire logic timer0_cmp_b_out_en, // Timer 0 compare B enable
  input wire logic timer0_cmp_b_out, // Timer 0 compare B value
  input wire logic analog_chan0_dig_disable, // Channel 0 digital disable
  output logic ext_reset_n // Reset pin level, active low
);
  // Output-value and direction storage, index is port
  logic [7:0] out_q [PPR_NPORT];
  logic [7:0] out_d [PPR_NPORT];
  logic [7:0] dir_q [PPR_NPORT];
  logic [7:0] dir_d [PPR_NPORT];
  // Read data register
  logic [7:0] rd_q, rd_d;
  // Registered pin drivers
  logic [7:0] pb_out_q, pb_out_d, pb_oe_q, pb_oe_d, pb_pu_q, pb_pu_d;
  logic [7:0] pc_out_q, pc_out_d, pc_oe_q, pc_oe_d, pc_pu_q, pc_pu_d;
  logic [7:0] pd_out_q, pd_out_d, pd_oe_q, pd_oe_d, pd_pu_q, pd_pu_d;
  logic [PPR_PE_W-1:0] pe_out_q, pe_out_d, pe_oe_q, pe_oe_d;
  logic [PPR_PE_W-1:0] pe_pu_q, pe_pu_d;
  logic rst_q, rst_d;
  // Synchronised pin levels
  logic [7:0] pb_s, pc_s, pd_s;
  logic [PPR_PE_W-1:0] pe_s;
  // Port E resolved signals
  logic [PPR_PE_W-1:0] pe_mux_out, pe_mux_oe, pe_mux_pu, pe_dig, pe_off;
  logic pe_rst_level;
  // Pin view per port for reads
  logic [7:0] pin_view [PPR_NPORT];

  // Port selected by an offset
  function automatic logic [1:0] port_of(input logic [3:0] a);
    logic [3:0] q;
    q = a / PPR_REGS_PER_PORT;
    return q[1:0];
  endfunction

  // Register kind selected by an offset
  function automatic logic [1:0] kind_of(input logic [3:0] a);
    logic [3:0] r;
    r = a % PPR_REGS_PER_PORT;
    return r[1:0];
  endfunction

  // Writable bits of a port
  function automatic logic [7:0] wmask(input logic [1:0] p);
    return (p == PPR_PORT_E) ? PPR_MASK_E : PPR_MASK_FULL;
  endfunction

  // Pin synchroniser, all ports in one bank
  ppr_sync #(
    .W(24 + PPR_PE_W)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .din({pe_in, pd_in, pc_in, pb_in}),
    .dout({pe_s, pd_s, pc_s, pb_s})
  );

  // Port E alternate functions
  ppr_pe_mux u_pe_mux (
    .dir(dir_q[PPR_PORT_E][PPR_PE_W-1:0]),
    .outv(out_q[PPR_PORT_E][PPR_PE_W-1:0]),
    .pin_sync(pe_s),
    .fuse_prog(reset_pin_disable_fuse),
    .xin_sel(osc_in_clk_sel),
    .xout_sel(osc_out_clk_sel),
    .cmp_en(timer0_cmp_b_out_en),
    .cmp(timer0_cmp_b_out),
    .adc_dis(analog_chan0_dig_disable),
    .pin_out(pe_mux_out),
    .pin_oe(pe_mux_oe),
    .pin_pullup(pe_mux_pu),
    .pin_dig(pe_dig),
    .io_off(pe_off),
    .reset_level(pe_rst_level)
  );

  // Pin views; they track the pins through the synchroniser, which resets to zero
  always_comb begin
    pin_view[PPR_PORT_B] = pb_s;
    pin_view[PPR_PORT_C] = pc_s;
    pin_view[PPR_PORT_D] = pd_s;
    pin_view[PPR_PORT_E] = {5'h00, pe_dig};
  end

  // Register writes
  always_comb begin
    logic [1:0] wp;
    wp = port_of(addr);
    for (int p = 0; p < PPR_NPORT; p++) begin
      out_d[p] = out_q[p];
      dir_d[p] = dir_q[p];
    end
    if (we && addr < PPR_OFF_END) begin
      unique case (kind_of(addr))
        PPR_K_OUT: out_d[wp] = wdata & wmask(wp);
        PPR_K_DIR: dir_d[wp] = wdata & wmask(wp);
        // Pin register write toggles output bits
        PPR_K_PIN: out_d[wp] = out_q[wp] ^ (wdata & wmask(wp));
        default: begin
        end
      endcase
    end
  end

  // Register storage
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int p = 0; p < PPR_NPORT; p++) begin
        out_q[p] <= PPR_OUT_RST;
        dir_q[p] <= PPR_DIR_RST;
      end
    end else begin
      for (int p = 0; p < PPR_NPORT; p++) begin
        out_q[p] <= out_d[p];
        dir_q[p] <= dir_d[p];
      end
    end
  end

  // Read data, present only the cycle after a read
  always_comb begin
    logic [1:0] rp;
    logic [7:0] rmask;
    rp = port_of(addr);
    rmask = wmask(rp);
    if (rp == PPR_PORT_E && !reset_pin_disable_fuse) begin
      rmask[PPR_PE_RST_BIT] = 1'b0;
    end
    rd_d = PPR_RD_IDLE;
    if (re && addr < PPR_OFF_END) begin
      unique case (kind_of(addr))
        // Stored output value
        PPR_K_OUT: rd_d = out_q[rp] & rmask;
        // Stored direction
        PPR_K_DIR: rd_d = dir_q[rp] & rmask;
        PPR_K_PIN: rd_d = pin_view[rp] & rmask;
        default: rd_d = PPR_RD_IDLE;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_q <= PPR_RD_IDLE;
    end else begin
      rd_q <= rd_d;
    end
  end

  // Pin driver next values
  always_comb begin
    // Direction gates drive, B to D
    pb_oe_d = dir_q[PPR_PORT_B];
    pb_out_d = out_q[PPR_PORT_B] & dir_q[PPR_PORT_B];
    pb_pu_d = out_q[PPR_PORT_B] & ~dir_q[PPR_PORT_B];
    pc_oe_d = dir_q[PPR_PORT_C];
    pc_out_d = out_q[PPR_PORT_C] & dir_q[PPR_PORT_C];
    pc_pu_d = out_q[PPR_PORT_C] & ~dir_q[PPR_PORT_C];
    pd_oe_d = dir_q[PPR_PORT_D];
    pd_out_d = out_q[PPR_PORT_D] & dir_q[PPR_PORT_D];
    pd_pu_d = out_q[PPR_PORT_D] & ~dir_q[PPR_PORT_D];
    // Port E comes resolved from the override logic
    pe_oe_d = pe_mux_oe;
    pe_out_d = pe_mux_out;
    pe_pu_d = pe_mux_pu;
    // Bit 0 feeds the reset circuitry
    rst_d = pe_rst_level;
  end

  // Pin driver registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pb_oe_q <= PPR_DIR_RST;
      pb_out_q <= PPR_OUT_RST;
      pb_pu_q <= PPR_OUT_RST;
      pc_oe_q <= PPR_DIR_RST;
      pc_out_q <= PPR_OUT_RST;
      pc_pu_q <= PPR_OUT_RST;
      pd_oe_q <= PPR_DIR_RST;
      pd_out_q <= PPR_OUT_RST;
      pd_pu_q <= PPR_OUT_RST;
      pe_oe_q <= '0;
      pe_out_q <= '0;
      pe_pu_q <= '0;
      rst_q <= 1'b1;
    end else begin
      pb_oe_q <= pb_oe_d;
      pb_out_q <= pb_out_d;
      pb_pu_q <= pb_pu_d;
      pc_oe_q <= pc_oe_d;
      pc_out_q <= pc_out_d;
      pc_pu_q <= pc_pu_d;
      pd_oe_q <= pd_oe_d;
      pd_out_q <= pd_out_d;
      pd_pu_q <= pd_pu_d;
      pe_oe_q <= pe_oe_d;
      pe_out_q <= pe_out_d;
      pe_pu_q <= pe_pu_d;
      rst_q <= rst_d;
    end
  end

  // Output wiring
  assign rdata = rd_q;
  assign pb_out = pb_out_q;
  assign pb_oe = pb_oe_q;
  assign pb_pullup = pb_pu_q;
  assign pc_out = pc_out_q;
  assign pc_oe = pc_oe_q;
  assign pc_pullup = pc_pu_q;
  assign pd_out = pd_out_q;
  assign pd_oe = pd_oe_q;
  assign pd_pullup = pd_pu_q;
  assign pe_out = pe_out_q;
  assign pe_oe = pe_oe_q;
  assign pe_pullup = pe_pu_q;
  assign ext_reset_n = rst_q;

  // Checks on pins and read data
  a_xout_release: assert property (@(posedge clk) disable iff (!rstn)
    osc_out_clk_sel |=> !pe_oe[PPR_PE_XOUT_BIT])
    else $error("Oscillator output pin still driven");
  a_xin_release: assert property (@(posedge clk) disable iff (!rstn)
    osc_in_clk_sel |=> !pe_oe[PPR_PE_XIN_BIT])
    else $error("Oscillator input pin still driven");
  a_rst_pin_io: assert property (@(posedge clk) disable iff (!rstn)
    (reset_pin_disable_fuse && dir_q[PPR_PORT_E][PPR_PE_RST_BIT])
    |=> pe_oe[PPR_PE_RST_BIT] && ext_reset_n
        && pe_out[PPR_PE_RST_BIT] == $past(out_q[PPR_PORT_E][PPR_PE_RST_BIT]))
    else $error("Bit 0 not acting as plain output");
  a_rst_pin_off: assert property (@(posedge clk) disable iff (!rstn)
    !reset_pin_disable_fuse |=> !pe_oe[PPR_PE_RST_BIT] && !pe_pullup[PPR_PE_RST_BIT])
    else $error("Reset pin used as I/O");
  a_rst_pin_read: assert property (@(posedge clk) disable iff (!rstn)
    (re && !reset_pin_disable_fuse && addr >= PPR_OFF_E_OUT && addr <= PPR_OFF_E_PIN)
    |=> rdata[PPR_PE_RST_BIT] == 1'b0)
    else $error("Reset pin bit read nonzero");
  a_cmp_b_drive: assert property (@(posedge clk) disable iff (!rstn)
    (timer0_cmp_b_out_en && dir_q[PPR_PORT_E][PPR_PE_XIN_BIT] && !osc_in_clk_sel)
    |=> pe_oe[PPR_PE_XIN_BIT] && pe_out[PPR_PE_XIN_BIT] == $past(timer0_cmp_b_out))
    else $error("Compare B value not on bit 1");
  a_adc_in_off: assert property (@(posedge clk) disable iff (!rstn)
    (analog_chan0_dig_disable && re && addr == PPR_OFF_E_PIN)
    |=> rdata[PPR_PE_XOUT_BIT] == 1'b0)
    else $error("Disabled bit 2 input read high");
  a_out_readback: assert property (@(posedge clk) disable iff (!rstn)
    (we && addr == PPR_OFF_B_OUT) ##1 (re && addr == PPR_OFF_B_OUT)
    |=> rdata == $past(wdata, 2))
    else $error("Output value readback wrong");
  a_dir_reset: assert property (@(posedge clk) disable iff (!rstn)
    $past(!rstn) |-> pb_oe == 8'h00 && pc_oe == 8'h00 && pd_oe == 8'h00 && pe_oe == '0)
    else $error("Pin driven right after reset");
  a_e_upper_zero: assert property (@(posedge clk) disable iff (!rstn)
    (re && addr >= PPR_OFF_E_OUT && addr <= PPR_OFF_E_PIN) |=> rdata[7:3] == 5'h00)
    else $error("Port E upper bits read nonzero");
  a_dir_drive: assert property (@(posedge clk) disable iff (!rstn)
    (we && addr == PPR_OFF_B_DIR) |=> ##1 pb_oe == $past(wdata, 2))
    else $error("Direction not reflected on pins");
  a_pin_sync: assert property (@(posedge clk) disable iff (!rstn)
    (re && addr == PPR_OFF_B_PIN) |=> rdata == $past(pb_in, 3))
    else $error("Pin read not two-stage synced");
endmodule

// ==== rtl/ppr_pkg.sv ====
package ppr_pkg;
  // Register bus widths
  localparam int PPR_AW = 4;
  localparam int PPR_DW = 8;
  // Number of implemented Port E pins
  localparam int PPR_PE_W = 3;
  // Number of ports, B to E
  localparam int PPR_NPORT = 4;
  // Port indices
  localparam logic [1:0] PPR_PORT_B = 2'h0;
  localparam logic [1:0] PPR_PORT_C = 2'h1;
  localparam logic [1:0] PPR_PORT_D = 2'h2;
  localparam logic [1:0] PPR_PORT_E = 2'h3;
  // Register kind inside a port triple
  localparam logic [1:0] PPR_K_OUT = 2'h0;
  localparam logic [1:0] PPR_K_DIR = 2'h1;
  localparam logic [1:0] PPR_K_PIN = 2'h2;
  // Registers per port
  localparam logic [3:0] PPR_REGS_PER_PORT = 4'h3;
  // Register offsets
  localparam logic [3:0] PPR_OFF_B_OUT = 4'h0;
  localparam logic [3:0] PPR_OFF_B_DIR = 4'h1;
  localparam logic [3:0] PPR_OFF_B_PIN = 4'h2;
  localparam logic [3:0] PPR_OFF_C_OUT = 4'h3;
  localparam logic [3:0] PPR_OFF_C_DIR = 4'h4;
  localparam logic [3:0] PPR_OFF_C_PIN = 4'h5;
  localparam logic [3:0] PPR_OFF_D_OUT = 4'h6;
  localparam logic [3:0] PPR_OFF_D_DIR = 4'h7;
  localparam logic [3:0] PPR_OFF_D_PIN = 4'h8;
  localparam logic [3:0] PPR_OFF_E_OUT = 4'h9;
  localparam logic [3:0] PPR_OFF_E_DIR = 4'ha;
  localparam logic [3:0] PPR_OFF_E_PIN = 4'hb;
  // First offset past the map
  localparam logic [3:0] PPR_OFF_END = 4'hc;
  // Reset values
  localparam logic [7:0] PPR_OUT_RST = 8'h00;
  localparam logic [7:0] PPR_DIR_RST = 8'h00;
  localparam logic [7:0] PPR_RD_IDLE = 8'h00;
  // Implemented bits per port
  localparam logic [7:0] PPR_MASK_FULL = 8'hff;
  localparam logic [7:0] PPR_MASK_E = 8'h07;
  // Port E bit positions
  localparam int PPR_PE_RST_BIT = 0;
  localparam int PPR_PE_XIN_BIT = 1;
  localparam int PPR_PE_XOUT_BIT = 2;
endpackage

// ==== rtl/ppr_sync.sv ====
`timescale 1ns/1ps
module ppr_sync #(
  parameter int W = 8 // Number of bits
) (
  input wire logic clk, // Clock
  input wire logic rstn, // Sync reset, active low
  input wire logic [W-1:0] din, // Asynchronous levels
  output logic [W-1:0] dout // Synchronised levels
);
  // First and second stage
  logic [W-1:0] s1_q, s1_d;
  logic [W-1:0] s2_q, s2_d;

  initial begin
    if (W < 1) begin
      $error("ppr_sync width must be at least one");
    end
  end

  // Next values of the two stages
  always_comb begin
    s1_d = din;
    s2_d = s1_q;
  end

  // Stage registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign dout = s2_q;
endmodule

// ==== rtl/ppr_pe_mux.sv ====
`timescale 1ns/1ps
module ppr_pe_mux
  import ppr_pkg::*;
(
  input wire logic [ppr_pkg::PPR_PE_W-1:0] dir, // Direction bits
  input wire logic [ppr_pkg::PPR_PE_W-1:0] outv, // Output-value bits
  input wire logic [ppr_pkg::PPR_PE_W-1:0] pin_sync, // Synced pin levels
  input wire logic fuse_prog, // Reset pin disable fuse programmed
  input wire logic xin_sel, // Clock uses oscillator input pin
  input wire logic xout_sel, // Clock uses oscillator output pin
  input wire logic cmp_en, // Timer 0 compare B output enable
  input wire logic cmp, // Timer 0 compare B output value
  input wire logic adc_dis, // Analog channel 0 digital disable
  output logic [ppr_pkg::PPR_PE_W-1:0] pin_out, // Pin drive value
  output logic [ppr_pkg::PPR_PE_W-1:0] pin_oe, // Pin drive enable
  output logic [ppr_pkg::PPR_PE_W-1:0] pin_pullup, // Pull-up enable
  output logic [ppr_pkg::PPR_PE_W-1:0] pin_dig, // Digital input view
  output logic [ppr_pkg::PPR_PE_W-1:0] io_off, // Pins withdrawn from I/O
  output logic reset_level // Level to the reset circuitry
);
  // Override signals per pin
  logic [PPR_PE_W-1:0] pullup_override_en, pullup_override_val;
  logic [PPR_PE_W-1:0] dir_override_en, dir_override_val;
  logic [PPR_PE_W-1:0] out_value_override_en, out_value_override_val;
  logic [PPR_PE_W-1:0] dig_in_en_override_en, dig_in_en_override_val;
  // Effective direction, value, input enable
  logic [PPR_PE_W-1:0] dir_eff, val_eff, die_eff;

  // Override table and pin resolution
  always_comb begin
    pullup_override_en = '0;
    pullup_override_val = '0;
    dir_override_en = '0;
    dir_override_val = '0;
    out_value_override_en = '0;
    out_value_override_val = '0;
    dig_in_en_override_en = '0;
    dig_in_en_override_val = '0;
    out_value_override_en[PPR_PE_XIN_BIT] = cmp_en;
    out_value_override_val[PPR_PE_XIN_BIT] = cmp;
    dig_in_en_override_en[PPR_PE_XOUT_BIT] = adc_dis;
    io_off[PPR_PE_XOUT_BIT] = xout_sel;
    io_off[PPR_PE_XIN_BIT] = xin_sel;
    io_off[PPR_PE_RST_BIT] = !fuse_prog;
    // Resolve each pin
    for (int i = 0; i < PPR_PE_W; i++) begin
      dir_eff[i] = dir_override_en[i] ? dir_override_val[i] : dir[i];
      val_eff[i] = out_value_override_en[i] ? out_value_override_val[i] : outv[i];
      die_eff[i] = dig_in_en_override_en[i] ? dig_in_en_override_val[i] : 1'b1;
      // Drive only when output and free
      pin_oe[i] = dir_eff[i] && !io_off[i];
      pin_out[i] = val_eff[i] && pin_oe[i];
      if (pullup_override_en[i]) begin
        pin_pullup[i] = pullup_override_val[i] && !io_off[i];
      end else begin
        pin_pullup[i] = !dir_eff[i] && outv[i] && !io_off[i];
      end
      pin_dig[i] = pin_sync[i] && die_eff[i] && !io_off[i];
    end
    reset_level = fuse_prog ? 1'b1 : pin_sync[PPR_PE_RST_BIT];
  end
endmodule

// ==== test/ppr_pin_model.sv ====
`timescale 1ns/1ps
module ppr_pin_model #(
  parameter int W = 8 // Pin count
) (
  input wire logic clk, // Bench clock
  input wire logic [W-1:0] drv, // Device drive value
  input wire logic [W-1:0] oe, // Device drive enable
  input wire logic [W-1:0] pu, // Device pull-up enable
  input wire logic [W-1:0] ext_en, // Board drives the pin
  input wire logic [W-1:0] ext_val, // Board drive value
  output logic [W-1:0] pin // Resolved pin level
);
  logic flt_q = 1'b0; // Level of an undriven pin
  logic flt_d; // Next level of an undriven pin
  // A floating pin wanders every cycle, so stale values never look valid
  always_comb begin
    flt_d = ~flt_q;
  end
  always_ff @(posedge clk) begin
    flt_q <= flt_d;
  end
  // Device drive wins, then the board, then the pull-up
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (oe[i]) begin
        pin[i] = drv[i];
      end else if (ext_en[i]) begin
        pin[i] = ext_val[i];
      end else if (pu[i]) begin
        pin[i] = 1'b1;
      end else begin
        pin[i] = flt_q;
      end
    end
  end
endmodule

// ==== test/ppr_ports_tb.sv ====
`timescale 1ns/1ps
module ppr_ports_tb;
  import ppr_pkg::*;
  logic clk = 1'b0; // 50 MHz clock
  logic rstn = 1'b0; // Sync reset, active low
  logic [3:0] addr = 4'h0; // Register offset
  logic [7:0] wdata = 8'h00; // Write data
  logic we = 1'b0; // Write strobe
  logic re = 1'b0; // Read strobe
  logic [7:0] rdata; // Read data
  logic [7:0] pin_a [3]; // Port B..D pin levels
  logic [7:0] o_a [3]; // Port B..D drive values
  logic [7:0] oe_a [3]; // Port B..D drive enables
  logic [7:0] pu_a [3]; // Port B..D pull-ups
  logic [7:0] xen_a [3] = '{8'hf0, 8'hf0, 8'hf0}; // Board drives high nibbles
  logic [7:0] xval_a [3] = '{8'ha5, 8'ha5, 8'ha5}; // Board drive values
  logic [2:0] pe_pin, pe_out, pe_oe, pe_pullup; // Port E pins
  logic [2:0] e_en = 3'h0; // Board drive enables, Port E
  logic [2:0] e_val = 3'h0; // Board drive values, Port E
  logic fuse = 1'b1; // Fuse programmed
  logic osc_in = 1'b0; // Clock uses oscillator input pin
  logic osc_out = 1'b0; // Clock uses oscillator output pin
  logic cmp_en = 1'b0; // Compare B enable
  logic cmp = 1'b0; // Compare B value
  logic adc_dis = 1'b0; // Channel 0 digital disable
  logic ext_reset_n; // Level to reset circuitry
  int num_errors = 0; // Mismatch count
  int samples_checked = 0; // Comparison count
  int cycles = 0; // Timeout counter

  // Clock generator
  always #10 clk = ~clk;

  ppr_ports i_ppr_ports (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .we(we), .re(re), .rdata(rdata),
    .pb_in(pin_a[0]), .pb_out(o_a[0]), .pb_oe(oe_a[0]), .pb_pullup(pu_a[0]),
    .pc_in(pin_a[1]), .pc_out(o_a[1]), .pc_oe(oe_a[1]), .pc_pullup(pu_a[1]),
    .pd_in(pin_a[2]), .pd_out(o_a[2]), .pd_oe(oe_a[2]), .pd_pullup(pu_a[2]),
    .pe_in(pe_pin), .pe_out(pe_out), .pe_oe(pe_oe), .pe_pullup(pe_pullup),
    .reset_pin_disable_fuse(fuse), .osc_in_clk_sel(osc_in), .osc_out_clk_sel(osc_out),
    .timer0_cmp_b_out_en(cmp_en), .timer0_cmp_b_out(cmp),
    .analog_chan0_dig_disable(adc_dis), .ext_reset_n(ext_reset_n));

  // Board models, one per port
  for (genvar g = 0; g < 3; g++) begin : g_pins
    ppr_pin_model #(.W(8)) u_pins (.clk(clk), .drv(o_a[g]), .oe(oe_a[g]), .pu(pu_a[g]),
      .ext_en(xen_a[g]), .ext_val(xval_a[g]), .pin(pin_a[g]));
  end
  ppr_pin_model #(.W(3)) u_pins_e (.clk(clk), .drv(pe_out), .oe(pe_oe), .pu(pe_pullup),
    .ext_en(e_en), .ext_val(e_val), .pin(pe_pin));

  // Compare and count
  task automatic chk(input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // One-cycle register write
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  // Read and compare; data stand the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    // Look mid-cycle, then realign later drives to a rising edge
    @(negedge clk);
    chk(exp, rdata);
    @(posedge clk);
  endtask

  // Write then read back with no idle cycle between the strobes
  task automatic wr_rd(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    @(negedge clk);
    chk(d, rdata);
    @(posedge clk);
  endtask

  // Enough cycles for registers, pin outputs and synchronisers
  task automatic settle;
    repeat (4) @(posedge clk);
  endtask

  task automatic scen_reset;
    rdc(PPR_OFF_B_OUT, PPR_OUT_RST);
    rdc(PPR_OFF_C_OUT, 8'h00);
    rdc(PPR_OFF_D_OUT, 8'h00);
    rdc(PPR_OFF_B_DIR, PPR_DIR_RST);
    rdc(PPR_OFF_C_DIR, 8'h00);
    rdc(PPR_OFF_D_DIR, 8'h00);
    rdc(PPR_OFF_E_OUT, 8'h00);
    rdc(PPR_OFF_E_DIR, 8'h00);
    chk(8'h00, oe_a[0] | oe_a[1] | oe_a[2]);
    // Unmapped place ignores writes and reads zero
    wr(PPR_OFF_END, 8'hff);
    rdc(PPR_OFF_END, 8'h00);
    wr_rd(PPR_OFF_B_OUT, 8'h5a);
    $display("test reset_values done");
  endtask

  // Low nibble driven by the port, high nibble by the board
  task automatic scen_port(input logic [3:0] base, input int p);
    wr(base, 8'h33);
    wr(base + 4'h1, 8'h0f);
    settle();
    rdc(base, 8'h33);
    rdc(base + 4'h1, 8'h0f);
    chk(8'h0f, oe_a[p]);
    chk(8'h03, o_a[p]);
    chk(8'h30, pu_a[p]);
    rdc(base + 4'h2, 8'ha3);
    // Writing the pin register toggles output-value bits
    wr(base + 4'h2, 8'h11);
    rdc(base, 8'h22);
    $display("test port %0d done", p);
  endtask

  task automatic scen_port_e;
    wr(PPR_OFF_E_OUT, 8'hff);
    rdc(PPR_OFF_E_OUT, 8'h07);
    wr(PPR_OFF_E_DIR, 8'hfa);
    rdc(PPR_OFF_E_DIR, 8'h02);
    wr(PPR_OFF_E_OUT, 8'h05);
    wr(PPR_OFF_E_DIR, 8'h07);
    settle();
    chk(8'h07, {5'h00, pe_oe});
    chk(8'h05, {5'h00, pe_out});
    rdc(PPR_OFF_E_PIN, 8'h05);
    chk(8'h01, {7'h00, ext_reset_n});
    // Fuse unprogrammed: bit 0 goes to the reset circuitry
    fuse <= 1'b0;
    e_en <= 3'b001;
    e_val <= 3'b000;
    settle();
    rdc(PPR_OFF_E_OUT, 8'h04);
    rdc(PPR_OFF_E_DIR, 8'h06);
    rdc(PPR_OFF_E_PIN, 8'h04);
    chk(8'h06, {5'h00, pe_oe});
    chk(8'h00, {7'h00, ext_reset_n});
    e_val <= 3'b001;
    settle();
    chk(8'h01, {7'h00, ext_reset_n});
    // Oscillator pins withdrawn one after the other
    osc_out <= 1'b1;
    settle();
    chk(8'h02, {5'h00, pe_oe});
    rdc(PPR_OFF_E_PIN, 8'h00);
    osc_in <= 1'b1;
    settle();
    chk(8'h00, {5'h00, pe_oe});
    chk(8'h00, {5'h00, pe_out});
    osc_out <= 1'b0;
    osc_in <= 1'b0;
    fuse <= 1'b1;
    e_en <= 3'b000;
    $display("test port_e done");
  endtask

  task automatic scen_cmp;
    wr(PPR_OFF_E_OUT, 8'h00);
    wr(PPR_OFF_E_DIR, 8'h02);
    cmp_en <= 1'b1;
    cmp <= 1'b1;
    settle();
    chk(8'h02, {5'h00, pe_out});
    chk(8'h02, {5'h00, pe_oe});
    chk(8'h00, {5'h00, pe_pullup});
    cmp <= 1'b0;
    settle();
    chk(8'h00, {5'h00, pe_out});
    cmp <= 1'b1;
    cmp_en <= 1'b0;
    settle();
    chk(8'h00, {5'h00, pe_out});
    $display("test compare done");
  endtask

  task automatic scen_adc;
    wr(PPR_OFF_E_DIR, 8'h00);
    wr(PPR_OFF_E_OUT, 8'h07);
    e_en <= 3'b111;
    e_val <= 3'b101;
    adc_dis <= 1'b1;
    settle();
    rdc(PPR_OFF_E_PIN, 8'h01);
    chk(8'h07, {5'h00, pe_pullup});
    adc_dis <= 1'b0;
    settle();
    rdc(PPR_OFF_E_PIN, 8'h05);
    $display("test analog_disable done");
  endtask

  // Second reset in mid-run clears what the ports hold
  task automatic scen_rerst;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rdc(PPR_OFF_B_DIR, 8'h00);
    rdc(PPR_OFF_D_OUT, 8'h00);
    chk(8'h00, oe_a[0]);
    $display("test second_reset done");
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    scen_reset();
    scen_port(PPR_OFF_B_OUT, 0);
    scen_port(PPR_OFF_C_OUT, 1);
    scen_port(PPR_OFF_D_OUT, 2);
    scen_port_e();
    scen_cmp();
    scen_adc();
    scen_rerst();
    give_verdict();
  end
endmodule
